/* logic/t16_pkg.sv */
// Shared constants for the 16-bit timer core: register map, fields, resets
package t16_pkg;

  // ------------------------------------------------------------
  // Register map (byte offsets on the 8-bit register port)
  // ------------------------------------------------------------
  localparam logic [3:0] ADR_CTRL_A = 4'h0;   // Mode low bits, output actions
  localparam logic [3:0] ADR_CTRL_B = 4'h1;   // Filter, edge, retrigger, mode, clock
  localparam logic [3:0] ADR_CNT_L  = 4'h2;   // Counter low byte
  localparam logic [3:0] ADR_CNT_H  = 4'h3;   // Counter high byte (via latch)
  localparam logic [3:0] ADR_CMPA_L = 4'h4;   // Compare A low byte
  localparam logic [3:0] ADR_CMPA_H = 4'h5;   // Compare A high byte
  localparam logic [3:0] ADR_CMPB_L = 4'h6;   // Compare B low byte
  localparam logic [3:0] ADR_CMPB_H = 4'h7;   // Compare B high byte
  localparam logic [3:0] ADR_CAP_L  = 4'h8;   // Capture low byte
  localparam logic [3:0] ADR_CAP_H  = 4'h9;   // Capture high byte (via latch)
  localparam logic [3:0] ADR_FLAG   = 4'hA;   // Interrupt flags, write one to clear
  localparam logic [3:0] ADR_MASK   = 4'hB;   // Interrupt mask
  localparam logic [3:0] ADR_PWR    = 4'hC;   // Power-off control

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int FLG_OVF  = 0;                // Overflow flag bit
  localparam int FLG_CMPA = 1;                // Compare A flag bit
  localparam int FLG_CMPB = 2;                // Compare B flag bit
  localparam int FLG_CAP  = 3;                // Capture flag bit
  localparam int CB_FILT  = 7;                // Noise filter enable
  localparam int CB_EDGE  = 6;                // Capture edge, one is rising
  localparam int CB_RTG   = 5;                // Retrigger enable

  // ------------------------------------------------------------
  // Values after reset and fixed counter values
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE  = 8'h00;    // Every byte register
  localparam logic [15:0] RST_WORD  = 16'h0000; // Every word register
  localparam logic [15:0] BOTTOM    = 16'h0000; // Lowest count
  localparam logic [15:0] MAXV      = 16'hFFFF; // Highest count
  localparam logic [15:0] TOP_8     = 16'h00FF; // Fixed top, 8 bit
  localparam logic [15:0] TOP_9     = 16'h01FF; // Fixed top, 9 bit
  localparam logic [15:0] TOP_10    = 16'h03FF; // Fixed top, 10 bit

  // ------------------------------------------------------------
  // Clock select codes and prescaler masks
  // ------------------------------------------------------------
  localparam logic [2:0] CS_OFF   = 3'h0;     // No source, counter stopped
  localparam logic [2:0] CS_DIV1  = 3'h1;     // System clock
  localparam logic [2:0] CS_DIV8  = 3'h2;     // System clock / 8
  localparam logic [2:0] CS_DIV64 = 3'h3;     // System clock / 64
  localparam logic [2:0] CS_DIV256 = 3'h4;    // System clock / 256
  localparam logic [2:0] CS_DIV1K = 3'h5;     // System clock / 1024
  localparam logic [2:0] CS_EXTF  = 3'h6;     // External pin, falling edge
  localparam logic [2:0] CS_EXTR  = 3'h7;     // External pin, rising edge
  localparam logic [9:0] PM_8     = 10'h007;  // Divide by 8 mask
  localparam logic [9:0] PM_64    = 10'h03F;  // Divide by 64 mask
  localparam logic [9:0] PM_256   = 10'h0FF;  // Divide by 256 mask
  localparam logic [9:0] PM_1K    = 10'h3FF;  // Divide by 1024 mask

  // ------------------------------------------------------------
  // Compare output actions and filter length
  // ------------------------------------------------------------
  localparam logic [1:0] COM_OFF = 2'h0;      // Pin held low
  localparam logic [1:0] COM_TOG = 2'h1;      // Toggle on match
  localparam logic [1:0] COM_CLR = 2'h2;      // Clear on match
  localparam logic [1:0] COM_SET = 2'h3;      // Set on match
  localparam int FILT_LEN = 4;                // Equal samples for a filtered level

endpackage : t16_pkg

/* logic/t16_clk_sel.sv */
// Timer tick source: prescaler and synchronised external clock pin
`timescale 1ns/1ns
module t16_clk_sel
  import t16_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  // Pin
  input  wire logic       ext_clock_pin,
  // Tick
  output logic            timer_tick
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic       s1;      // First sync stage
    logic       s2;      // Second sync stage
    logic       prev;    // Last synced level
    logic [9:0] div;     // Free running prescaler
    logic       tick;    // Registered tick
  } t16_clk_s;

  t16_clk_s r_reg;       // Current state
  t16_clk_s r_next;      // Next state

  // Prescaler divisor match
  function automatic logic hit(input logic [9:0] cnt, input logic [9:0] m);
    hit = (cnt & m) == m;
  endfunction : hit

  // Tick selection
  always_comb begin
    r_next      = r_reg;
    r_next.s1   = ext_clock_pin;
    r_next.s2   = r_reg.s1;
    r_next.prev = r_reg.s2;
    r_next.div  = run ? r_reg.div + 10'h001 : 10'h000;
    case (clk_sel)
      CS_DIV1:   r_next.tick = 1'b1;
      CS_DIV8:   r_next.tick = hit(r_reg.div, PM_8);
      CS_DIV64:  r_next.tick = hit(r_reg.div, PM_64);
      CS_DIV256: r_next.tick = hit(r_reg.div, PM_256);
      CS_DIV1K:  r_next.tick = hit(r_reg.div, PM_1K);
      CS_EXTF:   r_next.tick = r_reg.prev & ~r_reg.s2;
      CS_EXTR:   r_next.tick = ~r_reg.prev & r_reg.s2;
      default:   r_next.tick = 1'b0;   // No source selected
    endcase
    if (!run) begin
      r_next.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign timer_tick = r_reg.tick;

endmodule : t16_clk_sel

/* logic/t16_cap_filter.sv */
// Capture pin synchroniser with optional noise filter
`timescale 1ns/1ns
module t16_cap_filter
  import t16_pkg::*;
#(
  parameter int FLEN = FILT_LEN
)(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Control and pin
  input  wire logic filter_en,
  input  wire logic capture_pin,
  // Cleaned level
  output logic      level
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic            s1;    // First sync stage
    logic            s2;    // Second sync stage
    logic [FLEN-1:0] hist;  // Recent samples
    logic            lvl;   // Filtered level
  } t16_filt_s;

  t16_filt_s r_reg;         // Current state
  t16_filt_s r_next;        // Next state

  // Filter: level moves only after FLEN equal samples
  always_comb begin
    r_next      = r_reg;
    r_next.s1   = capture_pin;
    r_next.s2   = r_reg.s1;
    r_next.hist = {r_reg.hist[FLEN-2:0], r_reg.s2};
    if (!filter_en) begin
      r_next.lvl = r_reg.s2;
    end else if (&r_next.hist) begin
      r_next.lvl = 1'b1;
    end else if (~|r_next.hist) begin
      r_next.lvl = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level = r_reg.lvl;

endmodule : t16_cap_filter

/* logic/t16_core.sv */
// 16-bit timer core with shared high-byte latch on an 8-bit register port
`timescale 1ns/1ns
// Function
// - Word counter, compares, capture; byte control registers
// - One shared high-byte latch per timer
// - Low-byte write loads latch plus byte together
// - Counter or capture low-byte read copies upper byte into latch
// - Compare reads bypass latch, latch untouched
// - Tick from prescaler or pin; none stops
// - Buffered compares drive pins and set flags
// - Pin edge copies counter; optional noise filter
// - Top from fixed values, compare A, capture
// - Compare A top blocks channel A output in PWM modes
// - Signal bottom at zero, maximum at all-ones
// - Four flags, each gated by mask bit
// - Power-off bit set disables the timer
// - Counter write beats clear and count
// - Capture event retriggers like reaching top
// - Capture writable only when it is top
module t16_core
  import t16_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Pins
  input  wire logic       ext_clock_pin,
  input  wire logic       capture_pin,
  output logic            compare_output_pin_a,
  output logic            compare_output_pin_b,
  // Status
  output logic            irq,
  output logic            at_bottom,
  output logic            at_max
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  control_a;         // Mode low bits, output actions
    logic [7:0]  control_b;         // Filter, edge, retrigger, mode, clock
    logic [15:0] counter_value;     // Count
    logic [15:0] compare_a_value;   // Software view of compare A
    logic [15:0] compare_b_value;   // Software view of compare B
    logic [15:0] cmp_a_act;         // Active compare A
    logic [15:0] cmp_b_act;         // Active compare B
    logic [15:0] capture_value;     // Captured count
    logic [7:0]  hi_latch;          // Shared high-byte latch
    logic [3:0]  flags;             // Interrupt flags
    logic [3:0]  mask;              // Interrupt mask
    logic        power_off;         // Timer power-off bit
    logic        count_down;        // Direction in dual-slope modes
    logic        cap_prev;          // Last filtered capture level
    logic        oc_a;              // Channel A pin
    logic        oc_b;              // Channel B pin
    logic [7:0]  rdata;             // Read data
    logic        irq;               // Interrupt line
    logic        bottom;            // Counter at zero
    logic        max;               // Counter at all-ones
  } t16_core_s;

  t16_core_s r_reg;                 // Current state
  t16_core_s r_next;                // Next state
  logic      timer_tick;            // Tick from source select
  logic      cap_level;             // Filtered capture level

  // ------------------------------------------------------------
  // Mode decode helpers
  // ------------------------------------------------------------
  // Top of the count sequence for a mode
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ca,
                                         input logic [15:0] cp);
    case (m)
      4'h1, 4'h5:             top_of = TOP_8;
      4'h2, 4'h6:             top_of = TOP_9;
      4'h3, 4'h7:             top_of = TOP_10;
      4'h4, 4'h9, 4'hB, 4'hF: top_of = ca;
      4'h8, 4'hA, 4'hC, 4'hE: top_of = cp;
      default:                top_of = MAXV;
    endcase
  endfunction : top_of

  // Mode uses the capture register as top
  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
  endfunction : cap_is_top

  // Mode is a PWM mode
  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !((m == 4'h0) || (m == 4'h4) || (m == 4'hC) || (m == 4'hD));
  endfunction : is_pwm

  // Mode counts up and down
  function automatic logic is_dual(input logic [3:0] m);
    is_dual = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hB);
  endfunction : is_dual

  // Next pin level for one compare channel
  function automatic logic oc_step(input logic [1:0] com, input logic pwm,
                                   input logic dual, input logic down,
                                   input logic match, input logic wrap,
                                   input logic cur);
    logic act;
    act = cur;
    case (com)
      COM_TOG: act = match ? ~cur : cur;
      COM_CLR: begin
        if (pwm && dual) begin
          act = match ? down : cur;
        end else if (pwm) begin
          act = match ? 1'b0 : (wrap ? 1'b1 : cur);
        end else begin
          act = match ? 1'b0 : cur;
        end
      end
      COM_SET: begin
        if (pwm && dual) begin
          act = match ? ~down : cur;
        end else if (pwm) begin
          act = match ? 1'b1 : (wrap ? 1'b0 : cur);
        end else begin
          act = match ? 1'b1 : cur;
        end
      end
      default: act = 1'b0;
    endcase
    oc_step = act;
  endfunction : oc_step

  // ------------------------------------------------------------
  // Tick source and capture filter
  // ------------------------------------------------------------
  t16_clk_sel u_clk_sel (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .run           (!r_reg.power_off),
    .clk_sel       (r_reg.control_b[2:0]),
    .ext_clock_pin (ext_clock_pin),
    .timer_tick    (timer_tick)
  );

  t16_cap_filter u_cap_filter (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .filter_en   (r_reg.control_b[CB_FILT]),
    .capture_pin (capture_pin),
    .level       (cap_level)
  );

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic [3:0]  mode;     // Waveform mode
    logic [15:0] top;      // Current top
    logic        pwm;      // PWM mode
    logic        dual;     // Dual-slope mode
    logic        tick;     // Counting tick
    logic        top_hit;  // Count at top on a tick
    logic        match_a;  // Compare A match
    logic        match_b;  // Compare B match
    logic        ovf;      // Overflow event
    logic        cap_evt;  // Capture edge
    logic [3:0]  evts;     // Flag set events
    logic [3:0]  clr;      // Flag clear bits
    logic [15:0] wword;    // Latch plus written byte
    mode    = {r_reg.control_b[4:3], r_reg.control_a[1:0]};
    top     = top_of(mode, r_reg.cmp_a_act, r_reg.capture_value);
    pwm     = is_pwm(mode);
    dual    = is_dual(mode);
    tick    = timer_tick && !r_reg.power_off;
    top_hit = tick && (r_reg.counter_value == top);
    match_a = tick && (r_reg.counter_value == r_reg.cmp_a_act);
    match_b = tick && (r_reg.counter_value == r_reg.cmp_b_act);
    wword   = {r_reg.hi_latch, reg_wdata};
    clr     = 4'h0;
    r_next  = r_reg;
    r_next.rdata = RST_BYTE;

    // Overflow point depends on the counting sequence
    if (mode == 4'h4 || mode == 4'hC) begin
      ovf = tick && (r_reg.counter_value == MAXV);
    end else if (dual) begin
      ovf = tick && r_reg.count_down && (r_reg.counter_value == BOTTOM);
    end else begin
      ovf = top_hit;
    end

    // Capture edge on the filtered level
    r_next.cap_prev = cap_level;
    cap_evt = !r_reg.power_off && (cap_level != r_reg.cap_prev) &&
              (cap_level == r_reg.control_b[CB_EDGE]);
    if (cap_evt && !cap_is_top(mode)) begin
      r_next.capture_value = r_reg.counter_value;
    end

    // Counting sequence
    if (tick) begin
      if (dual) begin
        if (!r_reg.count_down && r_reg.counter_value == top) begin
          r_next.count_down    = 1'b1;
          r_next.counter_value = r_reg.counter_value - 16'h0001;
        end else if (r_reg.count_down && r_reg.counter_value == BOTTOM) begin
          r_next.count_down    = 1'b0;
          r_next.counter_value = r_reg.counter_value + 16'h0001;
        end else if (r_reg.count_down) begin
          r_next.counter_value = r_reg.counter_value - 16'h0001;
        end else begin
          r_next.counter_value = r_reg.counter_value + 16'h0001;
        end
      end else if (top_hit) begin
        r_next.counter_value = BOTTOM;
      end else begin
        r_next.counter_value = r_reg.counter_value + 16'h0001;
      end
    end

    // Retrigger acts as a top wrap
    if (cap_evt && r_reg.control_b[CB_RTG]) begin
      r_next.counter_value = BOTTOM;
      r_next.count_down    = 1'b0;
    end

    // Double-buffered compares: PWM modes update at top
    if (!pwm || top_hit) begin
      r_next.cmp_a_act = r_reg.compare_a_value;
      r_next.cmp_b_act = r_reg.compare_b_value;
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADR_CTRL_A: r_next.control_a = reg_wdata;
        ADR_CTRL_B: r_next.control_b = reg_wdata;
        ADR_CNT_L:  r_next.counter_value = wword;
        ADR_CMPA_L: begin
          r_next.compare_a_value = wword;
          if (!pwm) begin
            r_next.cmp_a_act = wword;
          end
        end
        ADR_CMPB_L: begin
          r_next.compare_b_value = wword;
          if (!pwm) begin
            r_next.cmp_b_act = wword;
          end
        end
        ADR_CAP_L: begin
          if (cap_is_top(mode)) begin
            r_next.capture_value = wword;
          end
        end
        ADR_CNT_H, ADR_CMPA_H, ADR_CMPB_H, ADR_CAP_H: begin
          r_next.hi_latch = reg_wdata;
        end
        ADR_FLAG:   clr = reg_wdata[3:0];
        ADR_MASK:   r_next.mask = reg_wdata[3:0];
        ADR_PWR:    r_next.power_off = reg_wdata[0];
        default:    r_next.hi_latch = r_next.hi_latch;             // Unmapped, ignored
      endcase
    end

    // Register reads, data one cycle later
    if (reg_rd) begin
      case (reg_addr)
        ADR_CTRL_A: r_next.rdata = r_reg.control_a;
        ADR_CTRL_B: r_next.rdata = r_reg.control_b;
        ADR_CNT_L: begin
          r_next.rdata    = r_reg.counter_value[7:0];
          r_next.hi_latch = r_reg.counter_value[15:8];
        end
        ADR_CAP_L: begin
          r_next.rdata    = r_reg.capture_value[7:0];
          r_next.hi_latch = r_reg.capture_value[15:8];
        end
        ADR_CNT_H, ADR_CAP_H: r_next.rdata = r_reg.hi_latch;
        ADR_CMPA_L: r_next.rdata = r_reg.compare_a_value[7:0];
        ADR_CMPA_H: r_next.rdata = r_reg.compare_a_value[15:8];
        ADR_CMPB_L: r_next.rdata = r_reg.compare_b_value[7:0];
        ADR_CMPB_H: r_next.rdata = r_reg.compare_b_value[15:8];
        ADR_FLAG:   r_next.rdata = {4'h0, r_reg.flags};
        ADR_MASK:   r_next.rdata = {4'h0, r_reg.mask};
        ADR_PWR:    r_next.rdata = {7'h00, r_reg.power_off};
        default:    r_next.rdata = RST_BYTE;
      endcase
    end

    // Flags: a set in the same cycle beats the clear
    evts = 4'h0;
    evts[FLG_OVF]  = ovf;
    evts[FLG_CMPA] = match_a;
    evts[FLG_CMPB] = match_b;
    evts[FLG_CAP]  = cap_evt;
    r_next.flags = (r_reg.flags & ~clr) | evts;
    r_next.irq   = |(r_next.flags & r_next.mask);

    // Compare output pins
    if (pwm && top_of(mode, 16'h0000, 16'h0001) == 16'h0000) begin
      r_next.oc_a = 1'b0;
    end else begin
      r_next.oc_a = oc_step(r_reg.control_a[7:6], pwm, dual, r_reg.count_down,
                            match_a, top_hit, r_reg.oc_a);
    end
    r_next.oc_b = oc_step(r_reg.control_a[5:4], pwm, dual, r_reg.count_down,
                          match_b, top_hit, r_reg.oc_b);

    // Bottom and maximum levels
    r_next.bottom = r_next.counter_value == BOTTOM;
    r_next.max    = r_next.counter_value == MAXV;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r_reg        <= '0;
      r_reg.bottom <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs straight from the state register
  // ------------------------------------------------------------
  assign reg_rdata            = r_reg.rdata;
  assign compare_output_pin_a = r_reg.oc_a;
  assign compare_output_pin_b = r_reg.oc_b;
  assign irq                  = r_reg.irq;
  assign at_bottom            = r_reg.bottom;
  assign at_max               = r_reg.max;

endmodule : t16_core

/* verification/t16_core_sva.sv */
// Port assertions for the 16-bit timer core
`timescale 1ns/1ns
module t16_core_sva
  import t16_pkg::*;
(
  input wire logic       sys_clk, rst, reg_wr, reg_rd, irq, at_bottom, at_max, compare_output_pin_a,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0]  lat_reg, cta_reg; // Shadow latch, shadow control A
  logic        ok_reg, hw;       // Shadow latch valid, high-byte write
  logic [15:0] ca_reg;           // Shadow compare A
  assign hw = reg_wr && reg_addr inside {ADR_CNT_H, ADR_CMPA_H, ADR_CMPB_H, ADR_CAP_H};
  // Shadow state built from the register port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {lat_reg, cta_reg, ok_reg, ca_reg} <= {8'h00, 8'h00, 1'b1, 16'h0000};
    end else begin
      lat_reg <= hw ? reg_wdata : lat_reg;
      ok_reg  <= hw || (ok_reg && !(reg_rd && reg_addr inside {ADR_CNT_L, ADR_CAP_L}));
      ca_reg  <= (reg_wr && reg_addr == ADR_CMPA_L) ? {lat_reg, reg_wdata} : ca_reg;
      cta_reg <= (reg_wr && reg_addr == ADR_CTRL_A) ? reg_wdata : cta_reg;
    end
  end
  sequence s_mask_off;
    reg_wr && reg_addr == ADR_MASK && reg_wdata == 8'h00 ##1 !(reg_wr && reg_addr == ADR_MASK);
  endsequence
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  ends_excl_a: assert property (!(at_bottom && at_max))
    else $error("bottom and max together");
  boot_bottom_a: assert property ($fell(rst) |-> at_bottom)
    else $error("no bottom after reset");
  mask_irq_a: assert property (s_mask_off |=> !irq)
    else $error("interrupt with all masked");
  latch_read_a: assert property (reg_rd && reg_addr == ADR_CNT_H && ok_reg |=> reg_rdata == lat_reg)
    else $error("high read not from latch");
  cmpa_low_a: assert property (reg_rd && reg_addr == ADR_CMPA_L |=> reg_rdata == $past(ca_reg[7:0]))
    else $error("compare low byte wrong");
  cmpa_high_a: assert property (reg_rd && reg_addr == ADR_CMPA_H |=> reg_rdata == $past(ca_reg[15:8]))
    else $error("compare high byte wrong");
  pin_off_a: assert property (cta_reg[7:6] == COM_OFF && $past(cta_reg[7:6]) == COM_OFF |->
    !compare_output_pin_a)
    else $error("compare pin not low");
endmodule : t16_core_sva
bind t16_core t16_core_sva i_sva (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .irq(irq),
  .at_bottom(at_bottom), .at_max(at_max), .compare_output_pin_a(compare_output_pin_a), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

/* verification/t16_cpu_model.sv */
// Bus master model of the 8-bit processor on the register port
`timescale 1ns/1ns
module t16_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr, reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 14'h0000;
  // One-cycle write strobe, data inverted once released
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    {reg_wdata, reg_wr} <= {~d, 1'b0};
  endtask : wr
  // One-cycle read strobe, data taken in the cycle after
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
endmodule : t16_cpu_model

/* verification/testbench.sv */
// Self-checking bench for the 16-bit timer core
`timescale 1ns/1ns
module testbench;
  import t16_pkg::*;
  logic       sys_clk = 1'b0, rst = 1'b1, irq, at_bottom, at_max, pa, pb, reg_wr, reg_rd, mx;
  logic       ep = 1'b0, cp = 1'b0; // External count and capture pins
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  int         lat, w[4], b[16], n, error_cnt = 0, check_count = 0, seed = 32'he825_42fb;
  logic [3:0] rl[9] = '{ADR_CNT_H, ADR_CNT_L, ADR_CMPA_H, ADR_CMPA_L, ADR_CMPB_L, ADR_CNT_H, ADR_CAP_L, ADR_CAP_H,
                        ADR_CMPB_H};
  logic [11:0] st[3] = '{12'hC01, 12'h100, 12'hC00};
  always #20 sys_clk = ~sys_clk;
  t16_core i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clock_pin(ep), .capture_pin(cp), .compare_output_pin_a(pa),
    .compare_output_pin_b(pb), .irq(irq), .at_bottom(at_bottom), .at_max(at_max));
  t16_cpu_model i_cpu (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Write through the bus and into the model
  task automatic mwr(input logic [3:0] a, input logic [7:0] v);
    i_cpu.wr(a, v);
    if (a inside {ADR_CNT_H, ADR_CMPA_H, ADR_CMPB_H, ADR_CAP_H}) lat = v;
    else if (a inside {ADR_CNT_L, ADR_CMPA_L, ADR_CMPB_L}) w[a[3:1] - 3'h1] = lat * 256 + v;
    else if (a inside {ADR_CTRL_A, ADR_CTRL_B, ADR_MASK, ADR_PWR}) b[a] = v;
  endtask : mwr
  // Read through the bus and compare with the model
  task automatic mrd(input logic [3:0] a);
    logic [7:0] e, r;
    int v;
    i_cpu.rd(a, r);
    v = (a inside {[ADR_CNT_L:ADR_CAP_H]}) ? w[a[3:1] - 3'h1] : b[a];
    e = (a inside {ADR_CNT_H, ADR_CAP_H}) ? lat[7:0] :
        (a inside {ADR_CMPA_H, ADR_CMPB_H}) ? v[15:8] : v[7:0];
    if (a inside {ADR_CNT_L, ADR_CAP_L}) lat = v[15:8];
    check(r, e);
  endtask : mrd
  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #1600000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) mrd(a[3:0]);
    repeat (6) begin
      for (int a = 3; a < 10; a += 2) begin
        mwr(a[3:0], 8'($random(seed)));
        mwr(a[3:0] - 4'h1, 8'($random(seed)));
      end
      foreach (rl[i]) mrd(rl[i]);
    end
    // Count through max and bottom, past compare A, short of compare B
    mwr(ADR_MASK, 8'h01);
    mwr(ADR_CMPA_H, 8'h00);
    mwr(ADR_CMPA_L, 8'h05);
    mwr(ADR_CMPB_L, 8'h80);
    mwr(ADR_CTRL_A, 8'h40);
    mwr(ADR_CNT_H, 8'hFF);
    mwr(ADR_CNT_L, 8'hF0);
    mwr(ADR_CTRL_B, {5'h00, CS_DIV1});
    n = 0;
    mx = 1'b0;
    while (at_bottom !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      mx |= at_max;
      n++;
    end
    check({6'h00, mx, at_bottom}, 8'h03);
    repeat (20) @(posedge sys_clk);
    i_cpu.rd(ADR_FLAG, d);
    check(d, 8'h03);
    check({6'h00, pa, pb}, 8'h02);
    check({7'h00, irq}, 8'h01);
    mwr(ADR_MASK, 8'h00);
    repeat (2) @(posedge sys_clk);
    check({7'h00, irq}, 8'h00);
    i_cpu.wr(ADR_FLAG, 8'h03);
    mrd(ADR_FLAG);
    // Power off, clock off, power on without clock: counter holds
    foreach (st[k]) begin
      mwr(st[k][11:8], st[k][7:0]);
      mwr(ADR_CNT_H, 8'h12);
      mwr(ADR_CNT_L, 8'h34);
      repeat (10) @(posedge sys_clk);
      mrd(ADR_CNT_L);
      mrd(ADR_CNT_H);
    end
    // Rising capture edge copies the stopped count and sets its flag
    mwr(ADR_CTRL_B, 8'h40);
    cp <= 1'b1;
    repeat (6) @(posedge sys_clk);
    w[3] = w[0];
    b[10] = 8'h08;
    mrd(ADR_FLAG);
    mrd(ADR_CAP_L);
    mrd(ADR_CAP_H);
    // Three rising edges on the external clock pin give three counts
    mwr(ADR_CTRL_B, {5'h00, CS_EXTR});
    repeat (6) begin
      ep <= ~ep;
      repeat (4) @(posedge sys_clk);
    end
    w[0] += 3;
    mrd(ADR_CNT_L);
    mrd(ADR_CNT_H);
    tally_and_finish();
  end
endmodule : testbench
